//--- dv/radio_irq_source_routing_bench.sv
// Purpose: Self-checking bench for the radio interrupt link and its controller
// Assumes: Controller reached over APB; radio events driven here
// Notes:   Strength flag is kept clear during the routing sweep
`timescale 1ns/1ps
module radio_irq_source_routing_bench;
	logic        pclk = 1'b0;
	logic        presetn;
	logic [1:0]  data_mode, radio_state;
	logic        sync_detect, addr_match, addr_filter_en, write_byte, payload_ready, crc_ok;
	logic        recovered_bit_clock, buf_full, buf_empty, overrun_event, tx_last_bit, pll_lock;
	logic [6:0]  buf_count;
	logic [5:0]  buffer_level_setting;
	logic [7:0]  signal_strength_event, paddr, q;
	logic        psel, penable, pwrite, pready, buf_flush, fill_active, tx_start;
	logic [31:0] pwdata, prdata;
	int          err_count, num_checks, flushes, f0;
	localparam logic [7:0] RT = rirq_pkg::REG_ROUTE;
	localparam logic [7:0] FL = rirq_pkg::REG_FILL;

	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		if (buf_flush === 1'b1) flushes++;
	end

	rirq_link_if link (.pclk);
	rirq_device u_rirq_device (.pclk, .presetn, .link(link), .data_mode, .radio_state,
		.sync_detect, .addr_match, .addr_filter_en, .write_byte, .payload_ready, .crc_ok,
		.recovered_bit_clock, .buf_full, .buf_empty, .buf_count, .buffer_level_setting,
		.overrun_event, .tx_last_bit, .signal_strength_event, .pll_lock, .buf_flush,
		.fill_active, .tx_start);
	rirq_host u_rirq_host (.pclk, .presetn, .link(link), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr());
	rirq_link_assertions u_rirq_link_assertions (.pclk, .presetn, .reg_addr(link.reg_addr),
		.reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .lock_pin_oe_n(link.lock_pin_oe_n));

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Called right after a rising edge; returns one edge after the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata[23:16];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Orders arriving while busy are dropped, so poll until idle
	task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, rirq_pkg::APB_CMD, {15'h0000, w, a, d});
		do begin
			apb(1'b0, rirq_pkg::APB_STATUS, 32'h00000000);
		end while (prdata[rirq_pkg::STAT_BUSY] !== 1'b0);
	endtask

	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		dev(1'b0, a, 8'h00);
		chk(n, e, q & m);
	endtask

	function automatic logic [7:0] exp_irq(input logic [1:0] s);
		logic [3:0] t0;
		logic [3:0] t1;
		if (data_mode == rirq_pkg::MODE_CONT) begin
			t0 = {sync_detect, sync_detect, 1'b0, sync_detect};
			t1 = {4{recovered_bit_clock}};
		end else begin
			t0 = {sync_detect, !buf_empty, write_byte, data_mode[1] & payload_ready};
			t1 = {buf_count >= {1'b0, buffer_level_setting}, 1'b0, buf_full, data_mode[1] & crc_ok};
		end
		return {6'h00, t1[s], t0[s]};
	endfunction

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		err_count++;
		$display("Error watchdog expected finish seen hang");
		results();
	end

	initial begin
		{data_mode, radio_state, sync_detect, addr_match, addr_filter_en, write_byte, payload_ready,
			crc_ok, recovered_bit_clock, buf_full, overrun_event, tx_last_bit, pll_lock, buf_count,
			signal_strength_event, psel, penable, pwrite, paddr, pwdata} = '0;
		buf_empty = 1'b1;
		buffer_level_setting = 6'h10;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("route", RT, 8'hFF, rirq_pkg::RST_ROUTE);
		rc("fill", FL, 8'hFF, rirq_pkg::RST_FILL);
		rc("level", rirq_pkg::REG_LEVEL, 8'hFF, 8'h00);
		buf_full <= 1'b1;
		buf_empty <= 1'b0;
		rc("buf flags", RT, 8'h06, 8'h06);
		$display("test reset done");
		dev(1'b1, rirq_pkg::REG_LEVEL, 8'hA5);
		dev(1'b1, FL, 8'h09);
		signal_strength_event <= 8'hA5;
		rc("strength equal", FL, 8'h04, 8'h00);
		signal_strength_event <= 8'hA6;
		rc("strength above", FL, 8'h04, 8'h04);
		signal_strength_event <= 8'h00;
		dev(1'b1, FL, 8'h05);
		signal_strength_event <= 8'hA6;
		rc("strength off", FL, 8'h04, 8'h00);
		signal_strength_event <= 8'h00;
		$display("test strength done");
		for (int m = 0; m < 3; m++) begin
			data_mode <= m[1:0];
			for (int s = 0; s < 4; s++) begin
				dev(1'b1, RT, {s[1:0], s[1:0], 4'h0});
				for (int v = 0; v < 2; v++) begin
					{write_byte, buf_empty, sync_detect, payload_ready, crc_ok, recovered_bit_clock,
						buf_full} <= v ? 7'b0011100 : 7'b1100011;
					radio_state <= v ? rirq_pkg::ST_STBY : rirq_pkg::ST_RX;
					buf_count <= v ? 7'h0F : 7'h10;
					repeat (2) @(posedge pclk);
					chk("irq lines", exp_irq(s[1:0]), {6'h00, link.irq1, link.irq0});
				end
			end
		end
		addr_filter_en <= 1'b1;
		addr_match <= 1'b1;
		sync_detect <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("addr match", 8'h01, {7'h00, link.irq0});
		addr_filter_en <= 1'b0;
		addr_match <= 1'b0;
		$display("test routing done");
		data_mode <= rirq_pkg::MODE_BUF;
		radio_state <= rirq_pkg::ST_TX;
		sync_detect <= 1'b0;
		buf_full <= 1'b1;
		dev(1'b1, RT, 8'h00);
		chk("tx irq1 full", 8'h01, {7'h00, link.irq1});
		chk("tx start full", 8'h01, {7'h00, tx_start});
		buf_full <= 1'b0;
		tx_last_bit <= 1'b1;
		@(posedge pclk);
		tx_last_bit <= 1'b0;
		rc("tx done", FL, 8'h20, 8'h20);
		chk("tx start idle", 8'h00, {7'h00, tx_start});
		dev(1'b1, RT, 8'h08);
		chk("tx irq1 done", 8'h01, {7'h00, link.irq1});
		chk("tx irq0 nempty", 8'h01, {7'h00, link.irq0});
		data_mode <= 2'h2;
		dev(1'b1, FL, 8'h01);
		chk("pkt below level", 8'h00, {6'h00, tx_start, link.irq0});
		buf_count <= 7'h10;
		repeat (2) @(posedge pclk);
		chk("pkt at level", 8'h03, {6'h00, tx_start, link.irq0});
		buf_count <= 7'h00;
		dev(1'b1, FL, 8'h11);
		chk("pkt nempty", 8'h03, {6'h00, tx_start, link.irq0});
		buf_empty <= 1'b1;
		data_mode <= rirq_pkg::MODE_BUF;
		repeat (2) @(posedge pclk);
		chk("buf empty no start", 8'h00, {6'h00, tx_start, link.irq0});
		buf_empty <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("buf nempty start", 8'h03, {6'h00, tx_start, link.irq0});
		$display("test transmit done");
		overrun_event <= 1'b1;
		@(posedge pclk);
		overrun_event <= 1'b0;
		rc("overrun set", RT, 8'h01, 8'h01);
		f0 = flushes;
		dev(1'b1, RT, 8'h01);
		rc("overrun clear", RT, 8'h01, 8'h00);
		chk("flush pulses", 8'h01, 8'(flushes - f0));
		$display("test overrun done");
		radio_state <= rirq_pkg::ST_RX;
		dev(1'b1, FL, 8'hC1);
		chk("manual fill on", 8'h01, {7'h00, fill_active});
		dev(1'b1, FL, 8'h81);
		chk("manual fill off", 8'h00, {7'h00, fill_active});
		dev(1'b1, FL, 8'h01);
		sync_detect <= 1'b1;
		@(posedge pclk);
		sync_detect <= 1'b0;
		rc("auto fill", FL, 8'h40, 8'h40);
		dev(1'b1, FL, 8'h41);
		rc("auto rearm", FL, 8'h40, 8'h00);
		$display("test fill done");
		pll_lock <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("lock pin", 8'h01, {7'h00, link.lock_pin});
		pll_lock <= 1'b0;
		rc("lock flag", FL, 8'h02, 8'h02);
		dev(1'b1, FL, 8'h02);
		rc("lock cleared", FL, 8'h03, 8'h00);
		pll_lock <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("lock pin float", 8'h00, {7'h00, link.lock_pin});
		$display("test lock done");
		results();
	end
endmodule // radio_irq_source_routing_bench

//--- dv/rirq_link_assertions.sv
// Purpose: Protocol and register checks on the radio interrupt link
// Assumes: One clock; the host issues one register access at a time
// Notes:   Shadows track only the plain read/write fields
`timescale 1ns/1ps
module rirq_link_assertions (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_ack,
	input wire logic       lock_pin_oe_n
);
	logic [7:0] lvl_q;
	logic [7:0] fill_q;
	logic [4:0] route_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Flag and status bits are masked out: their value depends on events outside the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_q <= rirq_pkg::RST_LEVEL;
			fill_q <= rirq_pkg::RST_FILL;
			route_q <= 5'h00;
		end else if (reg_wr) begin
			if (reg_addr == rirq_pkg::REG_LEVEL) lvl_q <= reg_wdata;
			if (reg_addr == rirq_pkg::REG_FILL) fill_q <= reg_wdata & 8'h99;
			if (reg_addr == rirq_pkg::REG_ROUTE) route_q <= reg_wdata[7:3];
		end
	end

	sequence s_req;
		reg_wr || reg_rd;
	endsequence
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_wr_lock(b);
		reg_wr && reg_addr == rirq_pkg::REG_FILL && reg_wdata[0] == b;
	endsequence

	a_ack_follows_req: assert property (s_req |=> reg_ack)
		else $error("ack missing after request");
	a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
		else $error("ack without request");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without read");
	a_level_readback: assert property (s_rd(rirq_pkg::REG_LEVEL) |=> reg_rdata == lvl_q)
		else $error("threshold readback wrong");
	a_fill_readback: assert property (s_rd(rirq_pkg::REG_FILL) |=> (reg_rdata & 8'h99) == fill_q)
		else $error("fill register readback wrong");
	a_route_readback: assert property (s_rd(rirq_pkg::REG_ROUTE) |=> reg_rdata[7:3] == route_q)
		else $error("route selects readback wrong");
	a_lock_pin_float: assert property (s_wr_lock(1'b0) |-> ##2 lock_pin_oe_n)
		else $error("lock pin still driven");
	a_lock_pin_drive: assert property (s_wr_lock(1'b1) |-> ##2 !lock_pin_oe_n)
		else $error("lock pin not driven");
endmodule // rirq_link_assertions

//--- hdl/rirq_device.sv
// Purpose: Interrupt source routing, buffer flags and status of the radio
// Assumes: Event inputs are synchronous to pclk; pulses last one cycle
// Notes:   Summary of operation follows
// Summary of operation
// RULE1: Rx/standby first line from two-bit select
// RULE2: Packet mode first line choices, address match
// RULE3: Rx/standby second line from two-bit select
// RULE4: Transmit second line: full or done
// RULE5: Read-only buffer full flag, bit two
// RULE6: Read-only active-low not-empty flag, bit one (code reads one while the buffer is not empty)
// RULE7: Overrun flag; writing one clears, flushes
// RULE8: Fill method bit: auto or manual
// RULE9: Auto fill status; write one rearms (code ignores the write while the overrun flag is set)
// RULE10: Manual fill: host starts, stops loading
// RULE11: Transmit done after last bit leaves
// RULE12: Buffered transmit start: full or nonempty
// RULE13: Packet transmit start: threshold or nonempty
// RULE14: Strength source enable bit, reset off
// RULE15: Strength flag over threshold, write clears
// RULE16: Lock status flag, write one clears
// RULE17: Lock enable drives pin or floats
// RULE18: Eight-bit strength threshold, reset zero
// RULE19: Buffer sources also work in standby
// RULE20: Interrupt lines refresh every clock cycle
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rirq_device (
	input  wire logic        pclk,
	input  wire logic        presetn,
	rirq_link_if.device      link,
	input  wire logic [1:0]  data_mode,
	input  wire logic [1:0]  radio_state,
	input  wire logic        sync_detect,
	input  wire logic        addr_match,
	input  wire logic        addr_filter_en,
	input  wire logic        write_byte,
	input  wire logic        payload_ready,
	input  wire logic        crc_ok,
	input  wire logic        recovered_bit_clock,
	input  wire logic        buf_full,
	input  wire logic        buf_empty,
	input  wire logic [6:0]  buf_count,
	input  wire logic [5:0]  buffer_level_setting,
	input  wire logic        overrun_event,
	input  wire logic        tx_last_bit,
	input  wire logic [7:0]  signal_strength_event,
	input  wire logic        pll_lock,
	output logic             buf_flush,
	output logic             fill_active,
	output logic             tx_start
);
	logic [1:0] irq0_sel_q;
	logic [1:0] irq1_sel_q;
	logic       tx_irq1_sel_q;
	logic       overrun_q;
	logic       fill_method_q;
	logic       fill_q;
	logic       tx_done_q;
	logic       tx_start_sel_q;
	logic       strength_en_q;
	logic       strength_event_flag_q;
	logic       lock_q;
	logic       lock_en_q;
	logic [7:0] strength_event_level_q;
	logic [7:0] rdata_q;
	logic       ack_q;
	logic       irq0_q;
	logic       irq1_q;
	logic       flush_q;
	logic       tx_start_q;
	logic       pin_o_q;
	logic       pin_oe_n_q;
	logic       irq0_d;
	logic       irq1_d;
	logic       tx_start_d;
	logic       not_empty;
	logic       at_level;
	logic       strength_hit;
	logic       wr_route;
	logic       wr_fill;
	logic       wr_level;
	logic       is_cont;
	logic       is_buf;
	logic       is_tx;
	logic       manual_now;

	assign not_empty = ~buf_empty;
	assign at_level  = buf_count >= {1'b0, buffer_level_setting};
	assign strength_hit = strength_en_q && (signal_strength_event > strength_event_level_q); // RULE14
	assign wr_route  = link.reg_wr && (link.reg_addr == rirq_pkg::REG_ROUTE);
	assign wr_fill   = link.reg_wr && (link.reg_addr == rirq_pkg::REG_FILL);
	assign wr_level  = link.reg_wr && (link.reg_addr == rirq_pkg::REG_LEVEL);
	assign is_cont   = data_mode == rirq_pkg::MODE_CONT;
	assign is_buf    = data_mode == rirq_pkg::MODE_BUF;
	assign is_tx     = radio_state == rirq_pkg::ST_TX;
	// A write that switches method acts on its own fill bit at once
	assign manual_now = wr_fill ? link.reg_wdata[rirq_pkg::FILL_METHOD] : fill_method_q; // RULE8

	// Routing fields and plain control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq0_sel_q     <= rirq_pkg::RST_ROUTE[rirq_pkg::ROUTE_IRQ0_HI:rirq_pkg::ROUTE_IRQ0_LO];
			irq1_sel_q     <= rirq_pkg::RST_ROUTE[rirq_pkg::ROUTE_IRQ1_HI:rirq_pkg::ROUTE_IRQ1_LO];
			tx_irq1_sel_q  <= rirq_pkg::RST_ROUTE[rirq_pkg::ROUTE_TXSEL];
			fill_method_q  <= rirq_pkg::RST_FILL[rirq_pkg::FILL_METHOD];
			tx_start_sel_q <= rirq_pkg::RST_FILL[rirq_pkg::FILL_TXSTART];
			strength_en_q  <= rirq_pkg::RST_FILL[rirq_pkg::FILL_STR_EN];
			lock_en_q      <= rirq_pkg::RST_FILL[rirq_pkg::FILL_LOCK_EN];
			strength_event_level_q <= rirq_pkg::RST_LEVEL; // RULE18
		end else begin
			if (wr_route) begin
				irq0_sel_q    <= link.reg_wdata[rirq_pkg::ROUTE_IRQ0_HI:rirq_pkg::ROUTE_IRQ0_LO];
				irq1_sel_q    <= link.reg_wdata[rirq_pkg::ROUTE_IRQ1_HI:rirq_pkg::ROUTE_IRQ1_LO];
				tx_irq1_sel_q <= link.reg_wdata[rirq_pkg::ROUTE_TXSEL];
			end
			if (wr_fill) begin
				fill_method_q  <= link.reg_wdata[rirq_pkg::FILL_METHOD]; // RULE8
				tx_start_sel_q <= link.reg_wdata[rirq_pkg::FILL_TXSTART];
				strength_en_q  <= link.reg_wdata[rirq_pkg::FILL_STR_EN]; // RULE14
				lock_en_q      <= link.reg_wdata[rirq_pkg::FILL_LOCK_EN];
			end
			if (wr_level)
				strength_event_level_q <= link.reg_wdata; // RULE18
		end
	end

	// Overrun: a new overrun in the clearing cycle keeps the flag set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_q <= 1'b0;
			flush_q   <= 1'b0;
		end else begin
			flush_q <= wr_route && link.reg_wdata[rirq_pkg::ROUTE_OVERRUN]; // RULE7
			if (overrun_event)
				overrun_q <= 1'b1; // RULE7
			else if (wr_route && link.reg_wdata[rirq_pkg::ROUTE_OVERRUN])
				overrun_q <= 1'b0; // RULE7
		end
	end

	// Fill bit: status in auto method, plain control in manual method
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_q <= 1'b0;
		end else if (manual_now) begin
			if (wr_fill)
				fill_q <= link.reg_wdata[rirq_pkg::FILL_CTRL]; // RULE10
		end else begin
			if (is_buf && sync_detect && !is_tx)
				fill_q <= 1'b1; // RULE9
			else if (wr_fill && link.reg_wdata[rirq_pkg::FILL_CTRL] && !overrun_q)
				fill_q <= 1'b0; // RULE9
		end
	end

	// Done flag is sticky until the next transmission is started
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_done_q <= 1'b0;
		end else if (tx_last_bit) begin
			tx_done_q <= 1'b1; // RULE11
		end else if (tx_start_d && !tx_start_q) begin
			tx_done_q <= 1'b0;
		end
	end

	// Strength and lock flags; hardware set wins over a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strength_event_flag_q <= 1'b0;
			lock_q                <= 1'b0;
		end else begin
			if (strength_hit)
				strength_event_flag_q <= 1'b1; // RULE15
			else if (wr_fill && link.reg_wdata[rirq_pkg::FILL_STR_FLAG])
				strength_event_flag_q <= 1'b0; // RULE15
			if (pll_lock)
				lock_q <= 1'b1; // RULE16
			else if (wr_fill && link.reg_wdata[rirq_pkg::FILL_LOCK])
				lock_q <= 1'b0; // RULE16
		end
	end

	// Source selection for both lines and the transmit start condition
	always_comb begin
		irq0_d     = 1'b0;
		irq1_d     = 1'b0;
		tx_start_d = 1'b0;
		if (is_tx) begin
			if (is_cont) begin
				irq1_d = recovered_bit_clock; // RULE4
			end else begin
				irq1_d = tx_irq1_sel_q ? tx_done_q : buf_full; // RULE4
				if (is_buf) begin
					irq0_d     = not_empty; // RULE12
					tx_start_d = tx_start_sel_q ? not_empty : buf_full; // RULE12
				end else begin
					irq0_d     = tx_start_sel_q ? not_empty : at_level; // RULE13
					tx_start_d = tx_start_sel_q ? not_empty : at_level; // RULE13
				end
			end
		end else begin
			// Standby and receive share one map so the buffer stays serviceable
			if (is_cont) begin
				irq0_d = (irq0_sel_q == 2'h1) ? strength_event_flag_q : sync_detect; // RULE1
				irq1_d = recovered_bit_clock; // RULE3
			end else begin
				case (irq0_sel_q)
					2'h0: irq0_d = is_buf ? 1'b0 : payload_ready; // RULE1 RULE2
					2'h1: irq0_d = write_byte; // RULE1 RULE2
					2'h2: irq0_d = not_empty; // RULE19
					2'h3: irq0_d = (!is_buf && addr_filter_en) ? addr_match : sync_detect; // RULE2
					default: irq0_d = 1'b0;
				endcase
				case (irq1_sel_q)
					2'h0: irq1_d = is_buf ? 1'b0 : crc_ok; // RULE3
					2'h1: irq1_d = buf_full; // RULE19
					2'h2: irq1_d = strength_event_flag_q; // RULE3
					2'h3: irq1_d = at_level; // RULE19
					default: irq1_d = 1'b0;
				endcase
			end
		end
	end

	// Registered outputs; lines follow their source one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq0_q     <= 1'b0;
			irq1_q     <= 1'b0;
			tx_start_q <= 1'b0;
			pin_o_q    <= 1'b0;
			pin_oe_n_q <= 1'b1;
		end else begin
			irq0_q     <= irq0_d; // RULE20
			irq1_q     <= irq1_d; // RULE20
			tx_start_q <= tx_start_d;
			pin_o_q    <= lock_q; // RULE17
			pin_oe_n_q <= ~lock_en_q; // RULE17
		end
	end

	// Register read port answers one cycle after the strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 8'h00;
			ack_q   <= 1'b0;
		end else begin
			ack_q <= link.reg_rd || link.reg_wr;
			if (link.reg_rd) begin
				case (link.reg_addr)
					rirq_pkg::REG_ROUTE: rdata_q <= {irq0_sel_q, irq1_sel_q, tx_irq1_sel_q,
						buf_full, not_empty, overrun_q}; // RULE5 RULE6
					rirq_pkg::REG_FILL: rdata_q <= {fill_method_q, fill_q, tx_done_q,
						tx_start_sel_q, strength_en_q, strength_event_flag_q, lock_q, lock_en_q};
					rirq_pkg::REG_LEVEL: rdata_q <= strength_event_level_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign link.reg_rdata     = rdata_q;
	assign link.reg_ack       = ack_q;
	assign link.irq0          = irq0_q;
	assign link.irq1          = irq1_q;
	assign link.lock_pin_o    = pin_o_q;
	assign link.lock_pin_oe_n = pin_oe_n_q;
	assign buf_flush          = flush_q;
	assign fill_active        = fill_q; // RULE10
	assign tx_start           = tx_start_q;
endmodule // rirq_device

//--- hdl/rirq_host.sv
// Purpose: Host controller issuing register accesses to the radio on APB orders
// Assumes: One outstanding register access at a time
// Notes:   Orders arriving while busy are dropped; poll the busy bit
`timescale 1ns/1ps
module rirq_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	rirq_link_if.host        link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum logic [0:0] {RIRQ_IDLE, RIRQ_WAIT} rirq_state_t;

	rirq_state_t state_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic [7:0]  addr_q;
	logic [7:0]  wdata_q;
	logic        wr_q;
	logic        rd_q;
	logic        is_wr_q;
	logic [7:0]  rdata_keep_q;
	logic        cmd_go;

	assign cmd_go = psel && penable && pready_q && pwrite && (paddr == rirq_pkg::APB_CMD);

	// APB slave: ready in the second access cycle, data from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q) begin
				if (!pwrite && paddr == rirq_pkg::APB_STATUS)
					prdata_q <= {8'h00, rdata_keep_q, 5'h00, link.lock_pin, link.irq1,
						link.irq0, 7'h00, state_q == RIRQ_WAIT};
				else
					prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Register access sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= RIRQ_IDLE;
			addr_q       <= 8'h00;
			wdata_q      <= 8'h00;
			wr_q         <= 1'b0;
			rd_q         <= 1'b0;
			is_wr_q      <= 1'b0;
			rdata_keep_q <= 8'h00;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (state_q)
				RIRQ_IDLE: begin
					if (cmd_go) begin
						addr_q  <= pwdata[rirq_pkg::CMD_ADDR_LO +: 8];
						wdata_q <= pwdata[7:0];
						is_wr_q <= pwdata[rirq_pkg::CMD_WRITE];
						wr_q    <= pwdata[rirq_pkg::CMD_WRITE]; // RULE7 RULE9 RULE10
						rd_q    <= !pwdata[rirq_pkg::CMD_WRITE];
						state_q <= RIRQ_WAIT;
					end
				end
				RIRQ_WAIT: begin
					if (link.reg_ack) begin
						if (!is_wr_q)
							rdata_keep_q <= link.reg_rdata;
						state_q <= RIRQ_IDLE;
					end
				end
				default: state_q <= RIRQ_IDLE;
			endcase
		end
	end

	assign link.reg_addr  = addr_q;
	assign link.reg_wdata = wdata_q;
	assign link.reg_wr    = wr_q;
	assign link.reg_rd    = rd_q;
	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = 1'b0;
endmodule // rirq_host

//--- hdl/rirq_link_if.sv
// Purpose: Link between the radio interrupt logic and its host controller
// Assumes: One clock; register requests are one-cycle strobes
// Notes:   Lock pin level is resolved here from its output enable
`timescale 1ns/1ps
interface rirq_link_if (
	input wire logic pclk
);
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_ack;
	logic       irq0;
	logic       irq1;
	logic       lock_pin_o;
	logic       lock_pin_oe_n;
	logic       lock_pin;

	// Undriven pin reads low through an assumed pull-down
	assign lock_pin = lock_pin_oe_n ? 1'b0 : lock_pin_o;

	modport device (
		input  reg_addr, reg_wr, reg_rd, reg_wdata,
		output reg_rdata, reg_ack, irq0, irq1, lock_pin_o, lock_pin_oe_n
	);
	modport host (
		output reg_addr, reg_wr, reg_rd, reg_wdata,
		input  reg_rdata, reg_ack, irq0, irq1, lock_pin
	);
endinterface : rirq_link_if

//--- hdl/rirq_pkg.sv
// Purpose: Shared constants for the radio interrupt routing link and its controller
// Assumes: Register port uses the device's own byte offsets
// Notes:   APB offsets belong to the controller only
package rirq_pkg;
	localparam logic [7:0] REG_ROUTE = 8'h0D;
	localparam logic [7:0] REG_FILL  = 8'h0E;
	localparam logic [7:0] REG_LEVEL = 8'h0F;

	// Route register fields
	localparam int ROUTE_IRQ0_HI = 7;
	localparam int ROUTE_IRQ0_LO = 6;
	localparam int ROUTE_IRQ1_HI = 5;
	localparam int ROUTE_IRQ1_LO = 4;
	localparam int ROUTE_TXSEL   = 3;
	localparam int ROUTE_FULL    = 2;
	localparam int ROUTE_NEMPTY  = 1;
	localparam int ROUTE_OVERRUN = 0;

	// Fill register fields
	localparam int FILL_METHOD   = 7;
	localparam int FILL_CTRL     = 6;
	localparam int FILL_TXDONE   = 5;
	localparam int FILL_TXSTART  = 4;
	localparam int FILL_STR_EN   = 3;
	localparam int FILL_STR_FLAG = 2;
	localparam int FILL_LOCK     = 1;
	localparam int FILL_LOCK_EN  = 0;

	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] RST_FILL  = 8'h01;
	localparam logic [7:0] RST_LEVEL = 8'h00;

	// Data handling modes; bit 1 set means packet mode
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_BUF  = 2'h1;

	// Radio states
	localparam logic [1:0] ST_STBY = 2'h0;
	localparam logic [1:0] ST_RX   = 2'h1;
	localparam logic [1:0] ST_TX   = 2'h2;

	// Controller APB map
	localparam logic [7:0] APB_CMD    = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam int CMD_ADDR_LO  = 8;
	localparam int CMD_WRITE    = 16;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_IRQ0    = 8;
	localparam int STAT_IRQ1    = 9;
	localparam int STAT_LOCK    = 10;
	localparam int STAT_RDATA_LO = 16;
endpackage : rirq_pkg
